//--- hdl/disk_adapter_pio_command_decoder.sv
// Programmed I/O command decoder and status registers of the disk adapter.
// Assumes a transfer engine on the same clock that reports the end of each
// channel_transfer; only the cable continuity pin is asynchronous.
`timescale 1ns/1ps
module disk_adapter_pio_command_decoder
    import pio_decoder_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // Command port from the channel
    input wire programmed_io_command_t i_cmd,
    output logic o_resp_valid,
    output logic [0:15] o_resp_data,
    // Transfer engine
    output logic o_xfer_start,
    output logic o_xfer_stop,
    output logic [0:15] o_control_vector,
    output logic [0:15] o_data_vector,
    input wire logic i_xfer_ended,
    input wire logic i_multisector_active,
    input wire logic i_data_op_active,
    input wire logic i_tag_seq_error,
    input wire logic i_fcb_timeout,
    input wire logic i_data_status_load,
    input wire logic [0:15] i_data_status,
    input wire adapter_cfg_t i_cfg,
    // Drive side
    input wire logic [0:2] i_seek_activity,
    input wire logic [0:5] i_flag_bits,
    input wire logic i_cable_pin,
    output logic o_drive_error_reset,
    output logic [0:15] o_seek_position,
    output logic [0:15] o_operation,
    output logic [0:7] o_first_value,
    // Status
    output logic o_irq_request,
    output logic o_busy
);
    logic [0:15] basic_status;
    logic [0:15] next_basic_status;
    logic [8:11] seek_error;
    logic [8:11] next_seek_error;
    logic [0:15] data_status;
    logic [0:15] control_vector;
    logic [0:15] data_vector;
    logic [0:15] operation;
    logic [0:15] seek_position;
    logic [0:7] first_value;
    logic [0:2] burst;
    logic [0:1] skip;
    logic [0:1] spiral;
    logic [0:5] fcb_error;
    logic [0:7] pulsing;
    logic cable_meta;
    logic cable_sync;
    term_state_t term_state;
    term_state_t next_term_state;
    logic [0:15] rd_value;
    logic known;

    // Command qualification
    wire [7:0] code = i_cmd.code;
    wire [0:15] op = i_cmd.operand;
    wire busy = basic_status[`BS_BUSY];
    wire bad_parity = i_cmd.valid && !i_cmd.parity_ok;
    wire restricted = (code == `CMD_INITIATE) || (code == `CMD_READ_FCB_STATUS)
        || (code == `CMD_WRITE_OPERATION) || (code == `CMD_WRITE_CTRL_VECTOR)
        || (code == `CMD_WRITE_DATA_VECTOR) || (code == `CMD_LOAD_SEEK)
        || (code == `CMD_READ_FIRST) || (code == `CMD_WRITE_FIRST);
    wire reject = i_cmd.valid && i_cmd.parity_ok && restricted && busy;
    wire exec = i_cmd.valid && i_cmd.parity_ok && known && !reject;
    wire invalid = i_cmd.valid && i_cmd.parity_ok && !known;
    wire cmd_error = invalid || reject || bad_parity;
    wire do_reset = exec && (code == `CMD_RESET_ADAPTER);
    wire do_clear = exec && (code == `CMD_RESET_MASK);
    wire do_set = exec && (code == `CMD_SET_MASK);
    // Initiation needs requests enabled, which the reset command withdraws
    wire do_start = exec && (code == `CMD_INITIATE) && basic_status[`BS_ENABLED];
    wire do_term = exec && (code == `CMD_TERMINATE) && busy;
    wire [0:15] change_mask = op & `BS_CHANGE_MASK;
    wire [0:15] vector_keep = ~`VECTOR_FIELD_MASK;
    wire [0:15] vector_load = op & `VECTOR_FIELD_MASK;
    // Multisector operation active, fixed-head selection pending, or a data op fetched after it finished
    wire defer = i_multisector_active
        || (i_seek_activity == `SEEK_MHS_FHS_BOTH)
        || (i_seek_activity == `SEEK_MHS_DONE_FHS)
        || ((i_seek_activity == `SEEK_MHS_FHS_DONE) && i_data_op_active);
    wire next_stop = do_reset || reject
        || ((term_state == TERM_DEFER) && !defer);

    always_comb begin
        unique case (code)
            `CMD_RESET_ADAPTER, `CMD_RESET_MASK, `CMD_READ_RESIDUAL, `CMD_SET_MASK,
            `CMD_READ_BASIC, `CMD_INITIATE, `CMD_TERMINATE, `CMD_READ_FCB_STATUS,
            `CMD_RESET_DRIVE, `CMD_READ_SEEK_STATUS, `CMD_READ_BURST,
            `CMD_WRITE_OPERATION, `CMD_WRITE_CTRL_VECTOR, `CMD_WRITE_DATA_VECTOR,
            `CMD_READ_SEEK, `CMD_LOAD_SEEK, `CMD_READ_FIRST, `CMD_WRITE_FIRST,
            `CMD_READ_DVEC_A, `CMD_READ_DVEC_B, `CMD_READ_DVEC_C, `CMD_READ_DVEC_D,
            `CMD_READ_CVEC_A, `CMD_READ_CVEC_B, `CMD_READ_CVEC_C: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    // Basic status update; hardware error sets come last so they win over clears
    always_comb begin
        next_basic_status = basic_status;
        if (do_reset) begin
            next_basic_status = '0;
        end
        if (do_clear) begin
            next_basic_status = next_basic_status & ~change_mask;
        end
        if (do_set) begin
            next_basic_status = next_basic_status | change_mask;
        end
        if (reject) begin
            next_basic_status[`BS_BUSY] = 1'b0;
        end
        if (i_xfer_ended && busy && !do_reset) begin
            next_basic_status[`BS_BUSY] = 1'b0;
            next_basic_status[`BS_IRQ] = 1'b1;
        end
        if (do_start) begin
            next_basic_status[`BS_BUSY] = 1'b1;
        end
        if (cmd_error) begin
            next_basic_status[`BS_EQ_CHECK] = 1'b1;
            next_basic_status[`BS_IRQ] = 1'b1;
        end
        if (bad_parity || i_fcb_timeout) begin
            next_basic_status[`BS_DEV_ERR] = 1'b1;
            next_basic_status[`BS_IRQ] = 1'b1;
        end
        if (i_tag_seq_error) begin
            next_basic_status[`BS_EQ_CHECK] = 1'b1;
        end
    end

    // Seek error bits follow the fall of their basic status partners
    always_comb begin
        next_seek_error = seek_error;
        if (!next_basic_status[`BS_EQ_CHECK]) begin
            next_seek_error[`SS_TAG_SEQ] = 1'b0;
            next_seek_error[`SS_CMD_ERR] = 1'b0;
        end
        if (!next_basic_status[`BS_DEV_ERR]) begin
            next_seek_error[`SS_CARD_ERR] = 1'b0;
            next_seek_error[`SS_TIMEOUT] = 1'b0;
        end
        if (do_reset) begin
            next_seek_error = '0;
        end
        if (cmd_error) begin
            next_seek_error[`SS_CMD_ERR] = 1'b1;
        end
        if (bad_parity) begin
            next_seek_error[`SS_CARD_ERR] = 1'b1;
        end
        if (i_tag_seq_error) begin
            next_seek_error[`SS_TAG_SEQ] = 1'b1;
        end
        if (i_fcb_timeout) begin
            next_seek_error[`SS_TIMEOUT] = 1'b1;
        end
    end

    always_comb begin
        next_term_state = term_state;
        unique case (term_state)
            TERM_IDLE: begin
                if (do_term) begin
                    next_term_state = TERM_DEFER;
                end
            end
            TERM_DEFER: begin
                if (!defer) begin
                    next_term_state = TERM_STOP;
                end
            end
            TERM_STOP: begin
                if (i_xfer_ended || !busy) begin
                    next_term_state = TERM_IDLE;
                end
            end
            default: next_term_state = TERM_IDLE;
        endcase
        if (do_reset || reject) begin
            next_term_state = TERM_IDLE;
        end
    end

    // Read data selection
    always_comb begin
        rd_value = '0;
        unique case (code)
            `CMD_READ_RESIDUAL: begin
                rd_value = {data_status[0:1], i_flag_bits, data_status[8:15]}
                    & `RESIDUAL_READ_MASK;
            end
            `CMD_READ_BASIC: rd_value = basic_status;
            `CMD_READ_FCB_STATUS: rd_value = {basic_status[0:7], `FCB_FILL, fcb_error};
            `CMD_READ_SEEK_STATUS: begin
                rd_value = {basic_status[0:7], seek_error, cable_sync, i_seek_activity};
            end
            `CMD_READ_BURST: begin
                rd_value = {6'h00, spiral, skip, 3'h0, burst};
            end
            `CMD_READ_SEEK: rd_value = seek_position;
            `CMD_READ_FIRST: rd_value = {first_value, pulsing};
            `CMD_READ_DVEC_A: rd_value = (data_vector & `VECTOR_FIELD_MASK)
                | {7'h00, `DVEC_TAG_A, 6'h00};
            `CMD_READ_DVEC_B: rd_value = (data_vector & `VECTOR_FIELD_MASK)
                | {7'h00, `DVEC_TAG_B, 6'h00};
            `CMD_READ_DVEC_C: rd_value = (data_vector & `VECTOR_FIELD_MASK)
                | {7'h00, `DVEC_TAG_C, 6'h00};
            `CMD_READ_DVEC_D: rd_value = (data_vector & `VECTOR_FIELD_MASK)
                | {7'h00, `DVEC_TAG_D, 6'h00};
            `CMD_READ_CVEC_A: rd_value = (control_vector & `VECTOR_FIELD_MASK)
                | {8'h00, `CVEC_TAG_A, 6'h00};
            `CMD_READ_CVEC_B: rd_value = (control_vector & `VECTOR_FIELD_MASK)
                | {8'h00, `CVEC_TAG_B, 6'h00};
            `CMD_READ_CVEC_C: rd_value = (control_vector & `VECTOR_FIELD_MASK)
                | {8'h00, `CVEC_TAG_C, 6'h00};
            default: rd_value = '0;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            basic_status <= '0;
            seek_error <= '0;
            term_state <= TERM_IDLE;
            cable_meta <= 1'b0;
            cable_sync <= 1'b0;
        end else begin
            basic_status <= next_basic_status;
            seek_error <= next_seek_error;
            term_state <= next_term_state;
            cable_meta <= i_cable_pin;
            cable_sync <= cable_meta;
        end
    end

    // Response and one-cycle strobes; a refused command stays silent
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_resp_valid <= 1'b0;
            o_resp_data <= '0;
            o_xfer_start <= 1'b0;
            o_xfer_stop <= 1'b0;
            o_drive_error_reset <= 1'b0;
        end else begin
            o_resp_valid <= i_cmd.valid && !reject;
            o_resp_data <= exec ? rd_value : '0;
            o_xfer_start <= do_start;
            o_xfer_stop <= next_stop;
            o_drive_error_reset <= exec && (code == `CMD_RESET_DRIVE);
        end
    end

    // Vector and operation registers; initiate loads only the vector field bits
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            control_vector <= '0;
            data_vector <= '0;
            operation <= '0;
        end else if (do_reset) begin
            control_vector <= '0;
            data_vector <= '0;
            operation <= '0;
        end else if (exec) begin
            if (code == `CMD_INITIATE) begin
                control_vector <= (control_vector & vector_keep) | vector_load;
            end
            if (code == `CMD_WRITE_CTRL_VECTOR) begin
                control_vector <= op;
            end
            if (code == `CMD_WRITE_DATA_VECTOR) begin
                data_vector <= op;
            end
            if (code == `CMD_WRITE_OPERATION) begin
                operation <= op;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            seek_position <= '0;
            first_value <= '0;
            data_status <= '0;
        end else if (do_reset) begin
            seek_position <= '0;
            first_value <= '0;
            data_status <= '0;
        end else begin
            if (exec && (code == `CMD_LOAD_SEEK)) begin
                seek_position <= {operation[0:1] == `RECAL_CODE, operation[2:6], 1'b0,
                    operation[7:15]};
            end
            if (exec && (code == `CMD_WRITE_FIRST)) begin
                first_value <= op[0:7];
            end
            if (i_data_status_load) begin
                data_status <= i_data_status;
            end
        end
    end

    // Counters loaded by control operations; reset command restores bursts
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            burst <= `BURST_RESET;
            skip <= '0;
            spiral <= '0;
            fcb_error <= '0;
            pulsing <= '0;
        end else if (do_reset) begin
            burst <= `BURST_RESET;
            skip <= '0;
            spiral <= '0;
            fcb_error <= '0;
            pulsing <= '0;
        end else if (i_cfg.load) begin
            burst <= i_cfg.burst;
            skip <= i_cfg.skip;
            spiral <= i_cfg.spiral;
            fcb_error <= i_cfg.fcb_error;
            pulsing <= i_cfg.pulsing;
        end
    end

    assign o_control_vector = control_vector;
    assign o_data_vector = data_vector;
    assign o_seek_position = seek_position;
    assign o_operation = operation;
    assign o_first_value = first_value;
    assign o_busy = busy;
    // Interrupt request needs both enable and request bits
    assign o_irq_request = basic_status[`BS_ENABLED] && basic_status[`BS_IRQ];
endmodule : disk_adapter_pio_command_decoder

//--- hdl/pio_decoder_defines.svh
// Command codes, bit positions and masks of the programmed I/O command decoder.
// Included by the package file only; definitions only.
`ifndef PIO_DECODER_DEFINES_SVH
`define PIO_DECODER_DEFINES_SVH

// Command codes
`define CMD_RESET_ADAPTER 8'h02
`define CMD_RESET_MASK 8'h04
`define CMD_READ_RESIDUAL 8'h05
`define CMD_SET_MASK 8'h06
`define CMD_READ_BASIC 8'h07
`define CMD_INITIATE 8'h08
`define CMD_TERMINATE 8'h0A
`define CMD_READ_FCB_STATUS 8'h0B
`define CMD_RESET_DRIVE 8'h0C
`define CMD_READ_SEEK_STATUS 8'h0D
`define CMD_READ_BURST 8'h21
`define CMD_WRITE_OPERATION 8'h22
`define CMD_WRITE_CTRL_VECTOR 8'h24
`define CMD_WRITE_DATA_VECTOR 8'h26
`define CMD_READ_SEEK 8'h29
`define CMD_LOAD_SEEK 8'h2A
`define CMD_READ_FIRST 8'h2D
`define CMD_WRITE_FIRST 8'h2E
`define CMD_READ_DVEC_A 8'h31
`define CMD_READ_DVEC_B 8'h33
`define CMD_READ_DVEC_C 8'h35
`define CMD_READ_DVEC_D 8'h37
`define CMD_READ_CVEC_A 8'h3B
`define CMD_READ_CVEC_B 8'h3D
`define CMD_READ_CVEC_C 8'h3F

// Basic status bit positions (bit 0 is the leftmost)
`define BS_DEV_ERR 9
`define BS_BUSY 11
`define BS_EQ_CHECK 13
`define BS_ENABLED 14
`define BS_IRQ 15

// Seek status bit positions
`define SS_TAG_SEQ 8
`define SS_CMD_ERR 9
`define SS_CARD_ERR 10
`define SS_TIMEOUT 11

// Masks and fixed values
`define BS_CHANGE_MASK 16'h00EF
`define RESIDUAL_READ_MASK 16'hFF3F
`define VECTOR_FIELD_MASK 16'h1C3E
`define BURST_RESET 3'h7
`define FCB_FILL 2'h3
`define DVEC_TAG_A 3'h7
`define DVEC_TAG_B 3'h0
`define DVEC_TAG_C 3'h2
`define DVEC_TAG_D 3'h3
`define CVEC_TAG_A 2'h0
`define CVEC_TAG_B 2'h2
`define CVEC_TAG_C 2'h3
`define RECAL_CODE 2'h1

// Seek activity codes that hold termination back; the first only while a data op is active
`define SEEK_MHS_FHS_DONE 3'h5
`define SEEK_MHS_FHS_BOTH 3'h6
`define SEEK_MHS_DONE_FHS 3'h7

`endif

//--- hdl/pio_decoder_pkg.sv
// Types shared by the programmed I/O command decoder and its surroundings.
// Assumes the defines header is on the include path.
`include "pio_decoder_defines.svh"
package pio_decoder_pkg;
    typedef struct packed {
        logic valid;
        logic parity_ok;
        logic [7:0] code;
        logic [0:15] operand;
    } programmed_io_command_t;

    typedef struct packed {
        logic load;
        logic [0:2] burst;
        logic [0:1] skip;
        logic [0:1] spiral;
        logic [0:5] fcb_error;
        logic [0:7] pulsing;
    } adapter_cfg_t;

    typedef enum logic [1:0] {
        TERM_IDLE = 2'h0,
        TERM_DEFER = 2'h1,
        TERM_STOP = 2'h2
    } term_state_t;
endpackage : pio_decoder_pkg

//--- tb/pio_decoder_checker.sv
// Port-level assertions for the programmed I/O command decoder.
// Assumes one clock domain and that the package is compiled first.
`timescale 1ns/1ps
module pio_decoder_checker
    import pio_decoder_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // Command port
    input wire programmed_io_command_t i_cmd,
    input wire logic o_resp_valid,
    input wire logic [0:15] o_resp_data,
    // Outputs watched
    input wire logic o_xfer_start,
    input wire logic o_xfer_stop,
    input wire logic [0:15] o_control_vector,
    input wire logic o_drive_error_reset,
    input wire logic [0:15] o_seek_position,
    input wire logic [0:15] o_operation,
    input wire logic [0:7] o_first_value,
    input wire logic o_irq_request,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    wire logic take = i_cmd.valid && i_cmd.parity_ok;
    wire logic [7:0] code = i_cmd.code;
    wire logic free = take && !o_busy;
    wire logic held = take && o_busy && (code inside
        {8'h08, 8'h0B, 8'h22, 8'h24, 8'h26, 8'h2A, 8'h2D, 8'h2E});

    a_basic_read_busy:
        assert property (take && code == 8'h07 |=>
            o_resp_valid && o_resp_data[11] == $past(o_busy))
        else $error("basic status read wrong");
    a_refused_silent:
        assert property (held |=> !o_resp_valid)
        else $error("restricted command answered while busy");
    a_refused_stops:
        assert property (held |-> ##[1:2] o_xfer_stop)
        else $error("restricted command did not end operation");
    a_start_busy:
        assert property (o_xfer_start |-> o_busy)
        else $error("transfer started without busy");
    a_vector_load:
        assert property (free && code == 8'h08 |=>
            o_control_vector[3:5] == $past(i_cmd.operand[3:5]) &&
            o_control_vector[10:14] == $past(i_cmd.operand[10:14]))
        else $error("control vector not loaded");
    a_drive_reset:
        assert property (take && code == 8'h0C |=> o_drive_error_reset)
        else $error("drive error reset missing");
    a_seek_from_op:
        assert property (free && code == 8'h2A |=> o_seek_position ==
            {$past(o_operation[0:1]) == 2'b01, $past(o_operation[2:6]), 1'b0,
            $past(o_operation[7:15])})
        else $error("seek register load wrong");
    a_first_write:
        assert property (free && code == 8'h2E |=> o_first_value == $past(i_cmd.operand[0:7]))
        else $error("first value not written");
    a_op_write:
        assert property (free && code == 8'h22 |=> o_operation == $past(i_cmd.operand))
        else $error("operation register not written");
    a_reset_cmd:
        assert property (take && code == 8'h02 |=>
            !o_busy && !o_irq_request && o_seek_position == 16'h0000)
        else $error("reset command left state behind");
    a_residual_zero:
        assert property (take && code == 8'h05 |=> o_resp_data[8:9] == 2'b00)
        else $error("residual bits 8 and 9 not zero");
endmodule : pio_decoder_checker

bind disk_adapter_pio_command_decoder pio_decoder_checker u_checker (.i_clock, .i_nrst,
    .i_cmd, .o_resp_valid, .o_resp_data, .o_xfer_start, .o_xfer_stop, .o_control_vector,
    .o_drive_error_reset, .o_seek_position, .o_operation, .o_first_value, .o_irq_request,
    .o_busy);

//--- tb/host_channel_model.sv
// Host channel: issues one command at a time and waits for the answer.
// Assumes the decoder answers within a few cycles; silence is a time-out.
`timescale 1ns/1ps
module host_channel_model
    import pio_decoder_pkg::*;
(
    // Clock
    input wire logic i_clock,
    // Command port
    output programmed_io_command_t o_cmd,
    input wire logic i_resp_valid,
    input wire logic [0:15] i_resp_data
);
    initial o_cmd = '0;

    task automatic issue(input logic [7:0] code, input logic [0:15] op, input logic par,
                         output logic [0:15] data, output logic answered);
        logic [0:15] opm;
        opm = op;
        if (code == 8'h08) opm[3:4] = 2'b00;
        answered = 1'b0;
        data = 16'h0000;
        @(posedge i_clock);
        o_cmd <= {1'b1, par, code, opm};
        @(posedge i_clock);
        // Released lines show the inverse, not a stale copy
        o_cmd <= {1'b0, 1'b1, ~code, ~opm};
        // Bounded wait stands in for the channel time-out
        for (int n = 0; n < 16 && !answered; n++) begin
            #1;
            if (i_resp_valid === 1'b1) begin
                answered = 1'b1;
                data = i_resp_data;
            end else begin
                @(posedge i_clock);
            end
        end
    endtask : issue
endmodule : host_channel_model

//--- tb/test_disk_adapter_pio_command_decoder.sv
// Self-checking bench for the programmed I/O command decoder.
// Assumes the host model drives the command port; engine replies to stops.
`timescale 1ns/1ps
module test_disk_adapter_pio_command_decoder
    import pio_decoder_pkg::*;
;
    typedef struct {logic [7:0] c; logic [0:15] op; logic [0:15] exp;} row_t;
    logic i_clock = 0, i_nrst = 0;
    programmed_io_command_t i_cmd;
    logic o_resp_valid, o_xfer_start, o_xfer_stop, o_drive_error_reset, o_irq_request, o_busy;
    logic [0:15] o_resp_data, o_control_vector, o_data_vector, o_seek_position, o_operation;
    logic [0:7] o_first_value;
    logic i_xfer_ended = 0, i_multisector_active = 0, i_fcb_timeout = 0;
    logic i_data_status_load = 0, i_data_op_active = 0, i_tag_seq_error = 0;
    logic [0:2] i_seek_activity = 3'h0;
    logic [0:15] i_data_status = 16'h0000;
    adapter_cfg_t i_cfg = '0;
    logic [0:15] got;
    logic ans;
    int errors = 0, n_checks = 0, n;
    row_t rows [0:34] = '{
        '{8'h07, 16'h0000, 16'h0000}, '{8'h21, 16'h0000, 16'h0242},
        '{8'h06, 16'h00FF, 16'h0000}, '{8'h07, 16'h0000, 16'h00EF},
        '{8'h04, 16'hFFFF, 16'h0000}, '{8'h07, 16'h0000, 16'h0000},
        '{8'h06, 16'h0081, 16'h0000}, '{8'h04, 16'h0080, 16'h0000},
        '{8'h07, 16'h0000, 16'h0001}, '{8'h22, 16'h4123, 16'h0000},
        '{8'h2A, 16'h0000, 16'h0000}, '{8'h29, 16'h0000, 16'h8123},
        '{8'h22, 16'h8F80, 16'h0000}, '{8'h2A, 16'h0000, 16'h0000},
        '{8'h29, 16'h0000, 16'h1D80}, '{8'h2E, 16'hA5FF, 16'h0000},
        '{8'h2D, 16'h0000, 16'hA53C}, '{8'h26, 16'hFFFF, 16'h0000},
        '{8'h31, 16'h0000, 16'h1DFE}, '{8'h33, 16'h0000, 16'h1C3E},
        '{8'h35, 16'h0000, 16'h1CBE}, '{8'h37, 16'h0000, 16'h1CFE},
        '{8'h24, 16'hFFFF, 16'h0000}, '{8'h3B, 16'h0000, 16'h1C3E},
        '{8'h3D, 16'h0000, 16'h1CBE}, '{8'h3F, 16'h0000, 16'h1CFE},
        '{8'h0B, 16'h0000, 16'h00D5}, '{8'h0D, 16'h0000, 16'h0008},
        '{8'h05, 16'h0000, 16'hFF3F}, '{8'h0C, 16'h0000, 16'h0000},
        '{8'h01, 16'h0000, 16'h0000}, '{8'h07, 16'h0000, 16'h0005},
        '{8'h0D, 16'h0000, 16'h0048}, '{8'h04, 16'hFFFF, 16'h0000},
        '{8'h0D, 16'h0000, 16'h0008}};

    always #20 i_clock = ~i_clock;
    // Engine acknowledges every stop one cycle later
    always @(posedge i_clock) i_xfer_ended <= o_xfer_stop;

    host_channel_model host (.i_clock(i_clock), .o_cmd(i_cmd), .i_resp_valid(o_resp_valid),
        .i_resp_data(o_resp_data));

    disk_adapter_pio_command_decoder dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_cmd(i_cmd),
        .o_resp_valid(o_resp_valid), .o_resp_data(o_resp_data), .o_xfer_start(o_xfer_start),
        .o_xfer_stop(o_xfer_stop), .o_control_vector(o_control_vector),
        .o_data_vector(o_data_vector), .i_xfer_ended(i_xfer_ended),
        .i_multisector_active(i_multisector_active), .i_data_op_active(i_data_op_active),
        .i_tag_seq_error(i_tag_seq_error), .i_fcb_timeout(i_fcb_timeout),
        .i_data_status_load(i_data_status_load), .i_data_status(i_data_status),
        .i_cfg(i_cfg), .i_seek_activity(i_seek_activity), .i_flag_bits(6'h3F),
        .i_cable_pin(1'b1),
        .o_drive_error_reset(o_drive_error_reset), .o_seek_position(o_seek_position),
        .o_operation(o_operation), .o_first_value(o_first_value),
        .o_irq_request(o_irq_request), .o_busy(o_busy));

    task automatic check(input string what, input logic [0:15] seen, input logic [0:15] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [7:0] c, input logic [0:15] exp);
        host.issue(c, 16'h0000, 1'b1, got, ans);
        check($sformatf("read %h", c), got, exp);
    endtask : rd

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic wait_idle();
        n = 0;
        while (o_busy !== 1'b0 && n < 64) begin
            @(posedge i_clock);
            n++;
        end
        if (n == 64) begin
            errors++;
            end_of_test();
        end
    endtask : wait_idle

    initial begin
        repeat (3) @(posedge i_clock);
        check("seek in reset", o_seek_position, 16'h0000);
        i_nrst <= 1;
        i_cfg <= '{1'b1, 3'b010, 2'b01, 2'b10, 6'h15, 8'h3C};
        i_data_status_load <= 1;
        i_data_status <= 16'hFFFF;
        @(posedge i_clock);
        i_cfg.load <= 0;
        i_data_status_load <= 0;
        for (int i = 0; i < 35; i++) begin
            host.issue(rows[i].c, rows[i].op, 1'b1, got, ans);
            check("answered", {15'h0000, ans}, 16'h0001);
            check($sformatf("row %0d", i), got, rows[i].exp);
        end
        check("data vector", o_data_vector, 16'hFFFF);
        $display("test table done");
        host.issue(8'h06, 16'h0002, 1'b1, got, ans);
        host.issue(8'h08, 16'hFFFF, 1'b1, got, ans);
        check("busy", {15'h0000, o_busy}, 16'h0001);
        check("control vector", o_control_vector, 16'hE7FF);
        rd(8'h07, 16'h0012);
        host.issue(8'h0B, 16'h0000, 1'b1, got, ans);
        check("refused", {15'h0000, ans}, 16'h0000);
        check("busy after refusal", {15'h0000, o_busy}, 16'h0000);
        rd(8'h07, 16'h0007);
        check("irq", {15'h0000, o_irq_request}, 16'h0001);
        $display("test refusal done");
        host.issue(8'h04, 16'hFFFF, 1'b1, got, ans);
        host.issue(8'h06, 16'h0002, 1'b1, got, ans);
        host.issue(8'h08, 16'h0000, 1'b1, got, ans);
        host.issue(8'h02, 16'h0000, 1'b1, got, ans);
        check("busy after reset", {15'h0000, o_busy}, 16'h0000);
        rd(8'h07, 16'h0000);
        rd(8'h21, 16'h0007);
        rd(8'h0D, 16'h0008);
        host.issue(8'h08, 16'h0000, 1'b1, got, ans);
        check("start disabled", {15'h0000, o_busy}, 16'h0000);
        $display("test adapter reset done");
        host.issue(8'h06, 16'h0002, 1'b1, got, ans);
        host.issue(8'h08, 16'h0000, 1'b1, got, ans);
        @(posedge i_clock);
        i_multisector_active <= 1;
        host.issue(8'h0A, 16'h0000, 1'b1, got, ans);
        repeat (8) @(posedge i_clock);
        check("deferred", {15'h0000, o_busy}, 16'h0001);
        i_multisector_active <= 0;
        wait_idle();
        rd(8'h07, 16'h0003);
        $display("test terminate done");
        host.issue(8'h08, 16'h0000, 1'b1, got, ans);
        @(posedge i_clock);
        i_seek_activity <= 3'h6;
        host.issue(8'h0A, 16'h0000, 1'b1, got, ans);
        // Pending selection, then selection after seek end, then fetched data op
        for (int k = 0; k < 3; k++) begin
            repeat (4) @(posedge i_clock);
            check("seek deferral", {15'h0000, o_busy}, 16'h0001);
            i_seek_activity <= (k == 0) ? 3'h7 : 3'h5;
            i_data_op_active <= (k < 2);
        end
        // Seek still moving; termination must not wait for it
        wait_idle();
        rd(8'h0D, 16'h000D);
        @(posedge i_clock);
        i_seek_activity <= 3'h0;
        $display("test seek deferral done");
        host.issue(8'h04, 16'hFFFF, 1'b1, got, ans);
        host.issue(8'h07, 16'h0000, 1'b0, got, ans);
        check("bad parity data", got, 16'h0000);
        rd(8'h07, 16'h0045);
        rd(8'h0D, 16'h0068);
        host.issue(8'h04, 16'hFFFF, 1'b1, got, ans);
        @(posedge i_clock);
        i_fcb_timeout <= 1;
        @(posedge i_clock);
        i_fcb_timeout <= 0;
        rd(8'h07, 16'h0041);
        rd(8'h0D, 16'h0018);
        @(posedge i_clock);
        i_tag_seq_error <= 1;
        @(posedge i_clock);
        i_tag_seq_error <= 0;
        rd(8'h0D, 16'h0098);
        $display("test errors done");
        end_of_test();
    end
endmodule : test_disk_adapter_pio_command_decoder
